// ### design/sdsw_defines.svh
// Purpose: Constants for the SYSREF divider skew-window qualifier.
// Assumes: Registers are word indices; byte address = index * 4.
// Notes: Definitions only.
//
// How it works
// - A SYSREF edge landing within the negative window before the divider edge is ignored.
// - A SYSREF edge landing within the positive window after the divider edge is ignored.
// - Negative field 00/01/10/11 means 0, 1/2, 1 and 1 1/2 device clocks of window.
// - Positive field 00/01/10/11 means 0, 1/2, 1 and 1 1/2 device clocks of window.
// - A zero field gives no tolerance on that side, so only an exact edge is tolerated.
// - The windows act only while auto phase adjust (control bit 7) is set.
// - An ignored SYSREF edge leaves the divider phase running undisturbed.
// - With auto adjust on, effective phase offset is captured status plus local offset.
// - The divider phase of the accepted SYSREF, in half cycles, is readable as status.
`ifndef SDSW_DEFINES_SVH
`define SDSW_DEFINES_SVH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define SDSW_IDX_LOCAL 14'h0109
`define SDSW_IDX_CTRL 14'h010a
`define SDSW_IDX_STATUS 14'h010b
`define SDSW_IDX_SYSMODE 14'h0120
`define SDSW_IDX_CAPT 14'h0129
`define SDSW_BADDR_LOCAL {`SDSW_IDX_LOCAL, 2'b00}
`define SDSW_BADDR_CTRL {`SDSW_IDX_CTRL, 2'b00}
`define SDSW_BADDR_STATUS {`SDSW_IDX_STATUS, 2'b00}
`define SDSW_BADDR_SYSMODE {`SDSW_IDX_SYSMODE, 2'b00}
`define SDSW_BADDR_CAPT {`SDSW_IDX_CAPT, 2'b00}

// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define SDSW_CTRL_AUTO_BIT 7
`define SDSW_CTRL_NEG_LSB 2
`define SDSW_CTRL_POS_LSB 0
`define SDSW_SYSMODE_LSB 1
`define SDSW_CTRL_RST 8'h00
`define SDSW_PHASE_RST 4'h0
`define SDSW_SYSMODE_RST 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define SDSW_HALVES_PER_CLK 5'h02
`define SDSW_DIV_RATIO_DEF 4

`endif

// ### design/sdsw_pkg.sv
// Purpose: Types for the SYSREF divider skew-window qualifier.
// Assumes: Nothing beyond the defines header.
// Notes: Types only; numbers live in the header.
package sdsw_pkg;

    // Control register layout, msb first
    typedef struct packed {
        logic autoEn;
        logic [2:0] rsvd;
        logic [1:0] negWin;
        logic [1:0] posWin;
    } sdsw_ctrl_s;

    // One qualified SYSREF capture
    typedef struct packed {
        logic edgeSeen;
        logic late;
    } sdsw_evt_s;

    typedef enum logic [1:0] {
        APB_IDLE = 2'b01,
        APB_ACK = 2'b10
    } sdsw_apb_e;

endpackage : sdsw_pkg

// ### design/sdsw_div_phase.sv
// Purpose: Input clock divider phase counter in half-cycle units.
// Assumes: DIV_RATIO of 2 or more.
// Notes: Advances two halves per clock; load realigns it.
`timescale 1ns/1ps
`default_nettype none
`include "sdsw_defines.svh"

module sdsw_div_phase #(
    parameter int DIV_RATIO = `SDSW_DIV_RATIO_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Realign
    input wire logic load,
    input wire logic [3:0] loadVal,
    // Phase
    output logic [3:0] phase
);
    localparam logic [4:0] PERIOD = 5'(2 * DIV_RATIO);

    logic [4:0] sum;

    always_comb begin
        sum = {1'b0, phase} + `SDSW_HALVES_PER_CLK;
        if (sum >= PERIOD) begin
            sum = sum - PERIOD;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            phase <= `SDSW_PHASE_RST;
        end else if (load) begin
            phase <= loadVal;
        end else begin
            phase <= sum[3:0];
        end
    end

endmodule : sdsw_div_phase

`default_nettype wire

// ### design/sdsw_top.sv
// Purpose: Skew-window qualifier for divider realignment to SYSREF, with APB registers.
// Assumes: SYSREF inputs synchronous to ref_clk; sysrefLate marks a half-cycle-late capture.
// Notes: APB access phase is two cycles; unmapped addresses answer with pslverr.
`timescale 1ns/1ps
`default_nettype none
`include "sdsw_defines.svh"

module sdsw_top
    import sdsw_pkg::*;
#(
    parameter int DIV_RATIO = `SDSW_DIV_RATIO_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // SYSREF capture
    input wire logic sysrefIn,
    input wire logic sysrefLate,
    // Divider view
    output logic [3:0] divPhase,
    output logic [3:0] effPhaseOffset,
    output logic sysrefAccepted,
    output logic sysrefIgnored
);
    localparam logic [4:0] PERIOD = 5'(2 * DIV_RATIO);

    // ----------------------------------------
    // Register state
    // ----------------------------------------
    sdsw_ctrl_s ctrl_q;
    logic [3:0] localPhase_q;
    logic [3:0] statusPhase_q;
    logic [3:0] captPhase_q;
    logic [1:0] sysMode_q;
    sdsw_apb_e apbState_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [3:0] effPhaseOffset_q;
    logic sysrefAccepted_q;
    logic sysrefIgnored_q;
    logic sysrefPrev_q;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    logic mapped;
    logic [31:0] rdMux;
    logic wrTake;

    always_comb begin
        mapped = 1'b1;
        rdMux = 32'h0000_0000;
        unique case (paddr)
            `SDSW_BADDR_LOCAL: rdMux = {28'h000_0000, localPhase_q};
            `SDSW_BADDR_CTRL: rdMux = {24'h00_0000, ctrl_q};
            `SDSW_BADDR_STATUS: rdMux = {28'h000_0000, statusPhase_q};
            `SDSW_BADDR_SYSMODE: rdMux = {29'h0000_0000, sysMode_q, 1'b0};
            `SDSW_BADDR_CAPT: rdMux = {28'h000_0000, captPhase_q};
            default: mapped = 1'b0;
        endcase
    end

    // Write lands on the edge where pready is sampled high
    assign wrTake = (apbState_q == APB_ACK) && psel && penable && pwrite && mapped;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            apbState_q <= APB_IDLE;
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            unique case (apbState_q)
                APB_IDLE: begin
                    if (psel && penable) begin
                        apbState_q <= APB_ACK;
                        pready_q <= 1'b1;
                        pslverr_q <= !mapped;
                        prdata_q <= pwrite ? 32'h0000_0000 : rdMux;
                    end
                end
                APB_ACK: begin
                    apbState_q <= APB_IDLE;
                    pready_q <= 1'b0;
                    pslverr_q <= 1'b0;
                    prdata_q <= 32'h0000_0000;
                end
            endcase
        end
    end

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `SDSW_CTRL_RST;
        end else if (wrTake && paddr == `SDSW_BADDR_CTRL) begin
            ctrl_q.autoEn <= pwdata[`SDSW_CTRL_AUTO_BIT];
            ctrl_q.rsvd <= 3'h0;
            ctrl_q.negWin <= pwdata[`SDSW_CTRL_NEG_LSB +: 2];
            ctrl_q.posWin <= pwdata[`SDSW_CTRL_POS_LSB +: 2];
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            localPhase_q <= `SDSW_PHASE_RST;
        end else if (wrTake && paddr == `SDSW_BADDR_LOCAL) begin
            localPhase_q <= pwdata[3:0];
        end
    end

    // Zero mode blocks SYSREF while windows are retuned
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sysMode_q <= `SDSW_SYSMODE_RST;
        end else if (wrTake && paddr == `SDSW_BADDR_SYSMODE) begin
            sysMode_q <= pwdata[`SDSW_SYSMODE_LSB +: 2];
        end
    end

    // ----------------------------------------
    // SYSREF capture and window test
    // ----------------------------------------
    sdsw_evt_s evt;
    logic [4:0] capSum;
    logic [3:0] capPhase;
    logic [4:0] negOff;
    logic [2:0] negHalves;
    logic [2:0] posHalves;
    logic inNeg;
    logic inPos;
    logic ignore;
    logic accept;

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sysrefPrev_q <= 1'b0;
        end else begin
            sysrefPrev_q <= sysrefIn;
        end
    end

    // One driver for the whole event word
    assign evt = {sysrefIn && !sysrefPrev_q && (sysMode_q != 2'h0), sysrefLate};

    // Field code equals its width in half device clocks
    assign negHalves = {1'b0, ctrl_q.negWin};
    assign posHalves = {1'b0, ctrl_q.posWin};

    always_comb begin
        capSum = {1'b0, divPhase} + {4'h0, evt.late};
        if (capSum >= PERIOD) begin
            capSum = capSum - PERIOD;
        end
        capPhase = capSum[3:0];
        negOff = PERIOD - {1'b0, capPhase};
    end

    // Phase zero is on the edge itself; a zero window tolerates only that
    assign inNeg = (capPhase != 4'h0) && (negOff <= {2'h0, negHalves});
    assign inPos = (capPhase != 4'h0) && (capPhase <= {1'b0, posHalves});
    assign ignore = evt.edgeSeen && ctrl_q.autoEn && (inNeg || inPos);
    assign accept = evt.edgeSeen && ctrl_q.autoEn && !(inNeg || inPos);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            sysrefAccepted_q <= 1'b0;
            sysrefIgnored_q <= 1'b0;
        end else begin
            sysrefAccepted_q <= accept;
            sysrefIgnored_q <= ignore;
        end
    end

    // ----------------------------------------
    // Divider and phase status
    // ----------------------------------------
    logic [3:0] loadVal;

    // Next clock lands one clock after the SYSREF instant, or half a clock after a late one
    assign loadVal = 4'(`SDSW_HALVES_PER_CLK - {4'h0, evt.late});

    // Ignored edges never load the divider
    sdsw_div_phase #(
        .DIV_RATIO(DIV_RATIO)
    ) u_div (
        .ref_clk(ref_clk),
        .rst_b(rst_b),
        .load(accept),
        .loadVal(loadVal),
        .phase(divPhase)
    );

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            captPhase_q <= `SDSW_PHASE_RST;
        end else if (evt.edgeSeen && ctrl_q.autoEn) begin
            captPhase_q <= capPhase;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            statusPhase_q <= `SDSW_PHASE_RST;
        end else if (accept) begin
            statusPhase_q <= capPhase;
        end
    end

    logic [3:0] effSum;

    // Wraps modulo 16 on purpose
    assign effSum = 4'(statusPhase_q + localPhase_q);

    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            effPhaseOffset_q <= `SDSW_PHASE_RST;
        end else begin
            effPhaseOffset_q <= ctrl_q.autoEn ? effSum : localPhase_q;
        end
    end

    // ----------------------------------------
    // Outputs
    // ----------------------------------------
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign effPhaseOffset = effPhaseOffset_q;
    assign sysrefAccepted = sysrefAccepted_q;
    assign sysrefIgnored = sysrefIgnored_q;

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    logic [4:0] advSum;
    logic [3:0] advPhase;

    always_comb begin
        advSum = {1'b0, divPhase} + `SDSW_HALVES_PER_CLK;
        if (advSum >= PERIOD) begin
            advSum = advSum - PERIOD;
        end
        advPhase = advSum[3:0];
    end

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    a_neg_window_drop: assert property (
        evt.edgeSeen && ctrl_q.autoEn && inNeg |=> sysrefIgnored_q && !sysrefAccepted_q
    ) else $error("edge in negative window not ignored");

    a_pos_window_drop: assert property (
        evt.edgeSeen && ctrl_q.autoEn && capPhase != 4'h0
        && capPhase <= {2'h0, ctrl_q.posWin} |=> sysrefIgnored_q
    ) else $error("edge in positive window not ignored");

    a_neg_decode_edge: assert property (
        evt.edgeSeen && ctrl_q.autoEn && capPhase != 4'h0 && !inPos
        && negOff == {3'h0, ctrl_q.negWin} + 5'h01 |=> sysrefAccepted_q
    ) else $error("edge just outside negative window not accepted");

    a_pos_decode_edge: assert property (
        evt.edgeSeen && ctrl_q.autoEn && !inNeg
        && capPhase == {2'h0, ctrl_q.posWin} + 4'h1 |=> sysrefAccepted_q
    ) else $error("edge just outside positive window not accepted");

    a_zero_window_exact: assert property (
        evt.edgeSeen && ctrl_q.autoEn && ctrl_q.negWin == 2'h0 && ctrl_q.posWin == 2'h0
        |=> sysrefAccepted_q ##0 statusPhase_q == $past(capPhase)
    ) else $error("zero windows must accept every edge");

    a_auto_off_gate: assert property (
        evt.edgeSeen && !ctrl_q.autoEn
        |=> !sysrefAccepted_q && !sysrefIgnored_q && divPhase == $past(advPhase)
    ) else $error("SYSREF acted while auto adjust was off");

    a_ignored_keeps_phase: assert property (
        ignore |=> divPhase == $past(advPhase) ##1 divPhase == $past(advPhase)
    ) else $error("ignored SYSREF disturbed divider");

    a_eff_offset_sum: assert property (
        sysrefAccepted_q && ctrl_q.autoEn && $stable(localPhase_q)
        |=> effPhaseOffset_q == $past(effSum)
    ) else $error("effective offset is not status plus local");

    a_status_capture: assert property (
        accept |=> statusPhase_q == $past(capPhase) && divPhase == $past(loadVal)
    ) else $error("status phase not captured on accept");

    c_sysref_accepted: cover property (accept ##1 sysrefAccepted_q);
    c_sysref_ignored: cover property (ignore && ctrl_q.negWin != 2'h0);
    c_ctrl_write: cover property (wrTake && paddr == `SDSW_BADDR_CTRL);

endmodule : sdsw_top

`default_nettype wire

// ### testbench/sdsw_sysref_src.sv
// Purpose: Model of the external SYSREF timing source, run from the bench ref_clk.
// Assumes: SYSREF edges are offered on a chosen residue of the divider span.
// Notes: The qualifier shows the inverse of its last value while no edge is offered.
`timescale 1ns/1ps
`default_nettype none

module sdsw_sysref_src #(
    parameter int R = 4
) (
    // Clock
    input wire logic ref_clk,
    // SYSREF drive
    output var logic sysrefIn,
    output var logic sysrefLate
);
    // ----------------------------------------
    // Edge source
    // ----------------------------------------
    int cnt = 0;

    initial begin
        sysrefIn = 1'b0;
        sysrefLate = 1'b1;
    end

    // Counted on the falling edge so it is stable at every rising edge
    always @(negedge ref_clk) begin
        cnt <= cnt + 1;
    end

    // Low for at least one sample between edges, so each call is one event
    task automatic fire(input int want, input logic late, output int e);
        for (int n = 0; n < 2 * R; n++) begin
            @(posedge ref_clk);
            if ((cnt + 1) % R == want) begin
                break;
            end
        end
        sysrefIn <= 1'b1;
        sysrefLate <= late;
        @(posedge ref_clk);
        e = cnt;
        sysrefIn <= 1'b0;
        sysrefLate <= ~late;
    endtask : fire
endmodule : sdsw_sysref_src

`default_nettype wire

// ### testbench/sysref_divider_skew_window_bench.sv
// Purpose: Self-checking bench for the SYSREF skew-window qualifier.
// Assumes: Divider phase is zero at each accepted edge and advances two halves a clock.
// Notes: Phase is tracked from the edge counter of the source, never read back.
`timescale 1ns/1ps
`default_nettype none
`include "sdsw_defines.svh"

module sysref_divider_skew_window_bench import sdsw_pkg::*;;
    localparam int R = 4;
    // Slave answers in the second access cycle
    localparam int APB_ACCESS = 2;
    logic ref_clk, rst_b, psel, penable, pwrite, sysrefIn, sysrefLate;
    logic pready, pslverr, sysrefAccepted, sysrefIgnored;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [3:0] divPhase, effPhaseOffset, localVal;
    int failures, comparisons, c0, off;

    sdsw_top #(.DIV_RATIO(R)) DUT (.ref_clk(ref_clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .sysrefIn(sysrefIn),
        .sysrefLate(sysrefLate), .divPhase(divPhase), .effPhaseOffset(effPhaseOffset),
        .sysrefAccepted(sysrefAccepted), .sysrefIgnored(sysrefIgnored));
    sdsw_sysref_src #(.R(R)) src (.ref_clk(ref_clk), .sysrefIn(sysrefIn),
        .sysrefLate(sysrefLate));

    always #20 ref_clk = ~ref_clk;

    // ----------------------------------------
    // Checking and bus tasks
    // ----------------------------------------
    task automatic stop_test();
        if (failures == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    task automatic cmpv(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmpv

    task automatic cmpb(input logic got, input logic exp);
        cmpv({31'h0, got}, {31'h0, exp});
    endtask : cmpb

    task automatic apb(input logic wr, input logic [15:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        // This wait ends when pready is high; only the watchdog ends a wait that never sees it
        @(posedge ref_clk);
        n = 1;
        while (pready !== 1'b1) begin
            @(posedge ref_clk);
            n++;
        end
        cmpv(32'(n), 32'(APB_ACCESS));
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rd_chk(input logic [15:0] a, input logic [31:0] exp, input logic eErr);
        logic [31:0] d;
        logic e;
        apb(1'b0, a, 32'h0, d, e);
        cmpv(d, exp);
        cmpb(e, eErr);
    endtask : rd_chk

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        logic [31:0] d;
        logic e;
        apb(1'b1, a, v, d, e);
        cmpb(e, 1'b0);
    endtask : wr

    // Windows only change while SYSREF is off
    task automatic set_ctrl(input sdsw_ctrl_s c, input logic [1:0] mode);
        wr(`SDSW_BADDR_SYSMODE, 32'h0);
        wr(`SDSW_BADDR_CTRL, {24'h0, c});
        wr(`SDSW_BADDR_SYSMODE, {29'h0, mode, 1'b0});
    endtask : set_ctrl

    task automatic sysref_edge(input int k, input logic late, input sdsw_ctrl_s c, input bit on);
        int e;
        int p;
        bit ign;
        src.fire((c0 + k) % R, late, e);
        p = (2 * (e - c0) - off + late) % (2 * R);
        ign = p != 0 && (p <= c.posWin || 2 * R - p <= c.negWin);
        @(negedge ref_clk);
        cmpb(sysrefAccepted, on && !ign);
        cmpb(sysrefIgnored, on && ign);
        if (on && !ign) begin
            c0 = e;
            off = late;
        end
        cmpv({28'h0, divPhase}, 32'((2 * (e + 1 - c0) - off) % (2 * R)));
        if (on) begin
            rd_chk(`SDSW_BADDR_CAPT, 32'(p), 1'b0);
        end
        if (on && !ign) begin
            rd_chk(`SDSW_BADDR_STATUS, 32'(p), 1'b0);
            cmpv({28'h0, effPhaseOffset}, 32'((p + localVal) % 16));
        end
    endtask : sysref_edge

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rd_chk(`SDSW_BADDR_LOCAL, 32'h0, 1'b0);
        rd_chk(`SDSW_BADDR_CTRL, 32'h0, 1'b0);
        rd_chk(`SDSW_BADDR_STATUS, 32'h0, 1'b0);
        rd_chk(`SDSW_BADDR_SYSMODE, 32'h0, 1'b0);
        rd_chk(`SDSW_BADDR_CAPT, 32'h0, 1'b0);
        rd_chk(16'h0000, 32'h0, 1'b1);
        wr(`SDSW_BADDR_CTRL, 32'hff);
        rd_chk(`SDSW_BADDR_CTRL, 32'h8f, 1'b0);
        wr(`SDSW_BADDR_SYSMODE, 32'hff);
        rd_chk(`SDSW_BADDR_SYSMODE, 32'h06, 1'b0);
        wr(`SDSW_BADDR_STATUS, 32'hf);
        rd_chk(`SDSW_BADDR_STATUS, 32'h0, 1'b0);
        wr(`SDSW_BADDR_LOCAL, 32'h5);
        localVal = 4'h5;
        rd_chk(`SDSW_BADDR_LOCAL, 32'h5, 1'b0);
    endtask : t_regs

    // Zero windows accept any edge, which fixes the tracked phase
    task automatic t_align();
        int e;
        set_ctrl(8'h80, 2'h1);
        src.fire(0, 1'b0, e);
        @(negedge ref_clk);
        cmpb(sysrefAccepted, 1'b1);
        c0 = e;
        off = 0;
    endtask : t_align

    task automatic t_windows();
        sdsw_ctrl_s c;
        for (int w = 0; w < 16; w++) begin
            c = sdsw_ctrl_s'({1'b1, 3'h0, 4'(w)});
            set_ctrl(c, 2'(w % 3 + 1));
            for (int k = 1; k <= R; k++) begin
                for (int l = 0; l < 2; l++) begin
                    sysref_edge(k, 1'(l), c, 1'b1);
                end
            end
        end
    endtask : t_windows

    task automatic t_gate();
        set_ctrl(8'h0f, 2'h3);
        sysref_edge(1, 1'b0, 8'h0f, 1'b0);
        cmpv({28'h0, effPhaseOffset}, {28'h0, localVal});
        set_ctrl(8'h83, 2'h0);
        sysref_edge(2, 1'b1, 8'h83, 1'b0);
    endtask : t_gate

    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 16'h0;
        pwdata = 32'h0;
        localVal = 4'h0;
        failures = 0;
        comparisons = 0;
        c0 = 0;
        off = 0;
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'b1;
        t_regs();
        t_align();
        t_windows();
        t_gate();
        stop_test();
    end

    // Roughly ten times the expected run
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        stop_test();
    end
endmodule : sysref_divider_skew_window_bench

`default_nettype wire
